/* dtlh_regs.svh */
// constants for the dfi training and write-path low-power handshake block
// Operation
// - low-power request carries a four-bit selector of sixteen wakeup times
// - controller acknowledges phy read eye request by raising read eye enable
// - controller may raise read eye enable on its own initiative
// - controller acknowledges phy gate training request by raising gate enable
// - controller may raise gate enable itself without a phy request
// - controller acknowledges phy write training request by raising write enable
// - controller may raise write training enable on its own initiative
// - during write leveling, sampled phy response steers the strobe delay setting
`ifndef DTLH_REGS_SVH
`define DTLH_REGS_SVH
`define DTLH_WAKEUP_W 4
`define DTLH_NUM_WAKEUP 16
`define DTLH_NUM_CH 3
`define DTLH_CH_RDLVL 0
`define DTLH_CH_GATE 1
`define DTLH_CH_WRLVL 2
`define DTLH_CLK_MHZ 25
`define DTLH_STROBE_GAP_NS 400
`define DTLH_STROBE_GAP_CYC ((`DTLH_STROBE_GAP_NS * `DTLH_CLK_MHZ + 999) / 1000)
`define DTLH_RESP_WAIT_NS 160
`define DTLH_RESP_WAIT_CYC ((`DTLH_RESP_WAIT_NS * `DTLH_CLK_MHZ + 999) / 1000)
`define DTLH_CNT_W 8
`define DTLH_DLY_W 6
`define DTLH_DLY_RESET 6'h00
`endif

/* dtlh_pkg.sv */
// types shared by the training handshake block
`default_nettype none
`include "dtlh_regs.svh"
package dtlh_pkg;
   typedef enum logic {CH_IDLE, CH_ACTIVE} dtlh_ch_state_t;
   typedef enum logic [2:0] {WL_IDLE, WL_GAP, WL_STROBE, WL_SAMPLE, WL_DONE} dtlh_wl_state_t;
   typedef struct packed {
      logic phy_req;
      logic self_start;
      logic resp;
   } dtlh_chan_req_t;
   typedef struct packed {
      logic en;
      logic done;
      logic phy_init;
   } dtlh_chan_stat_t;
   typedef struct packed {
      logic req;
      logic [`DTLH_WAKEUP_W-1:0] wakeup;
   } dtlh_lp_t;
endpackage
`default_nettype wire

/* dtlh_train_chan.sv */
// one training enable handshake channel
`timescale 1ns/1ps
`default_nettype none
module dtlh_train_chan #(
   parameter int CS_W = 2
) (
   input wire logic clock,
   input wire logic resetn,
   input wire dtlh_pkg::dtlh_chan_req_t req,
   input wire logic grant,
   input wire logic [CS_W-1:0] cs_n_in,
   output logic want,
   output var dtlh_pkg::dtlh_chan_stat_t stat,
   output logic [CS_W-1:0] cs_n_q
);
   import dtlh_pkg::*;
   dtlh_ch_state_t state_q;
   logic pend_q;
   logic start;

   assign want = (state_q == CH_IDLE) & (pend_q | req.phy_req | req.self_start);
   assign start = want & grant;

   // a self start that loses arbitration is remembered, not dropped
   always_ff @(posedge clock) begin
      if (!resetn) begin
         pend_q <= 1'b0;
      end else if (req.self_start && !start) begin
         pend_q <= 1'b1;
      end else if (start) begin
         pend_q <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_q <= CH_IDLE;
         stat <= '0;
         cs_n_q <= '1;
      end else begin
         stat.done <= 1'b0;
         case (state_q)
            CH_IDLE: begin
               if (start) begin
                  state_q <= CH_ACTIVE;
                  stat.en <= 1'b1;
                  stat.phy_init <= req.phy_req;
                  if (req.phy_req) begin
                     cs_n_q <= cs_n_in;
                  end
               end
            end
            CH_ACTIVE: begin
               if (req.resp) begin
                  state_q <= CH_IDLE;
                  stat.en <= 1'b0;
                  stat.done <= 1'b1;
               end
            end
            default: begin
               state_q <= CH_IDLE;
               stat.en <= 1'b0;
            end
         endcase
      end
   end

   a_en_holds_high: assert property (@(posedge clock) disable iff (!resetn)
      stat.en && !req.resp |=> stat.en)
      else $error("enable dropped before response");
   a_en_drops_resp: assert property (@(posedge clock) disable iff (!resetn)
      stat.en && req.resp |=> !stat.en && stat.done ##1 !stat.done)
      else $error("enable not released after response");
   a_phy_req_ack: assert property (@(posedge clock) disable iff (!resetn)
      (state_q == CH_IDLE) && req.phy_req && grant |=> stat.en && stat.phy_init)
      else $error("phy request not acknowledged");
   a_self_start_en: assert property (@(posedge clock) disable iff (!resetn)
      (state_q == CH_IDLE) && req.self_start && !req.phy_req && grant
      |=> stat.en && !stat.phy_init)
      else $error("self start did not raise enable");
endmodule
`default_nettype wire

/* dtlh_ctrl.sv */
// dfi write-path low-power and training handshake controller
`timescale 1ns/1ps
`default_nettype none
`include "dtlh_regs.svh"
module dtlh_ctrl #(
   parameter int CS_W = 2,
   parameter int DLY_W = `DTLH_DLY_W
) (
   input wire logic clock,
   input wire logic resetn,
   input wire dtlh_pkg::dtlh_lp_t lp_in,
   output var dtlh_pkg::dtlh_lp_t dfi_wrlp,
   input wire logic dfi_wrlp_ack,
   output logic wrlp_ack_seen_q,
   input wire logic dfi_rdlvl_req,
   input wire logic [CS_W-1:0] dfi_rdlvl_cs_n,
   input wire logic dfi_rdlvl_gate_req,
   input wire logic dfi_rdlvl_resp,
   input wire logic dfi_wrlvl_req,
   input wire logic [CS_W-1:0] dfi_wrlvl_cs_n,
   input wire logic dfi_wrlvl_resp,
   input wire logic [`DTLH_NUM_CH-1:0] self_start,
   output logic dfi_rdlvl_en,
   output logic dfi_rdlvl_gate_en,
   output logic dfi_wrlvl_en,
   output logic dfi_wrlvl_strobe,
   output logic [`DTLH_NUM_CH-1:0] train_done_q,
   output logic [`DTLH_NUM_CH-1:0] train_phy_init_q,
   output logic [CS_W-1:0] rd_cs_n_q,
   output logic [CS_W-1:0] wr_cs_n_q,
   output logic [DLY_W-1:0] wrlvl_delay_q,
   output logic wrlvl_fail_q
);
   import dtlh_pkg::*;

   localparam logic [`DTLH_CNT_W-1:0] GAP_CYC = `DTLH_CNT_W'(`DTLH_STROBE_GAP_CYC);
   localparam logic [`DTLH_CNT_W-1:0] WAIT_CYC = `DTLH_CNT_W'(`DTLH_RESP_WAIT_CYC);
   localparam logic [DLY_W-1:0] DLY_MAX = '1;

   dtlh_chan_req_t ch_req [`DTLH_NUM_CH];
   dtlh_chan_stat_t ch_stat [`DTLH_NUM_CH];
   logic [`DTLH_NUM_CH-1:0] ch_want;
   logic [`DTLH_NUM_CH-1:0] ch_en;
   logic [`DTLH_NUM_CH-1:0] grant;
   logic [CS_W-1:0] ch_cs_in [`DTLH_NUM_CH];
   logic [CS_W-1:0] ch_cs_q [`DTLH_NUM_CH];
   logic [`DTLH_NUM_CH-1:0] phy_req_v;
   dtlh_wl_state_t wl_q;
   logic [`DTLH_CNT_W-1:0] cnt_q;
   logic wl_done_q;

   // lowest set bit wins; one training at a time keeps the shared read response unambiguous
   function automatic logic [`DTLH_NUM_CH-1:0] pick_low(input logic [`DTLH_NUM_CH-1:0] v);
      logic [`DTLH_NUM_CH-1:0] r;
      r = v & (~v + `DTLH_NUM_CH'(1));
      return r;
   endfunction

   assign phy_req_v = {dfi_wrlvl_req, dfi_rdlvl_gate_req, dfi_rdlvl_req};
   assign grant = (|ch_en) ? '0 : pick_low(ch_want);
   assign ch_cs_in[`DTLH_CH_RDLVL] = dfi_rdlvl_cs_n;
   assign ch_cs_in[`DTLH_CH_GATE] = dfi_rdlvl_cs_n;
   assign ch_cs_in[`DTLH_CH_WRLVL] = dfi_wrlvl_cs_n;

   genvar gi;
   generate
      for (gi = 0; gi < `DTLH_NUM_CH; gi++) begin : g_ch
         assign ch_req[gi].phy_req = phy_req_v[gi];
         assign ch_req[gi].self_start = self_start[gi];
         // read channels finish on the phy's own verdict, write on the leveling engine
         if (gi == `DTLH_CH_WRLVL) begin : g_wr
            assign ch_req[gi].resp = wl_done_q;
         end else begin : g_rd
            assign ch_req[gi].resp = dfi_rdlvl_resp;
         end
         assign ch_en[gi] = ch_stat[gi].en;
         dtlh_train_chan #(
            .CS_W(CS_W)
         ) dtlh_train_chan_inst (
            .clock(clock),
            .resetn(resetn),
            .req(ch_req[gi]),
            .grant(grant[gi]),
            .cs_n_in(ch_cs_in[gi]),
            .want(ch_want[gi]),
            .stat(ch_stat[gi]),
            .cs_n_q(ch_cs_q[gi])
         );
      end
   endgenerate

   always_comb begin
      dfi_rdlvl_en = ch_stat[`DTLH_CH_RDLVL].en;
      dfi_rdlvl_gate_en = ch_stat[`DTLH_CH_GATE].en;
      dfi_wrlvl_en = ch_stat[`DTLH_CH_WRLVL].en;
      wr_cs_n_q = ch_cs_q[`DTLH_CH_WRLVL];
      for (int i = 0; i < `DTLH_NUM_CH; i++) begin
         train_done_q[i] = ch_stat[i].done;
         train_phy_init_q[i] = ch_stat[i].phy_init;
      end
   end

   // low-power request and wakeup selector go out together; ack is only reported
   always_ff @(posedge clock) begin
      if (!resetn) begin
         dfi_wrlp <= '0;
         wrlp_ack_seen_q <= 1'b0;
      end else begin
         dfi_wrlp <= lp_in;
         wrlp_ack_seen_q <= dfi_wrlp_ack & dfi_wrlp.req;
      end
   end

   // combined read select registered so the output leaves a flop; one cycle late
   always_ff @(posedge clock) begin
      if (!resetn) begin
         rd_cs_n_q <= '1;
      end else begin
         rd_cs_n_q <= ch_cs_q[`DTLH_CH_RDLVL] & ch_cs_q[`DTLH_CH_GATE];
      end
   end

   // write leveling: strobe, wait, sample response, step delay until it reads high or the delay reaches its maximum
   always_ff @(posedge clock) begin
      if (!resetn) begin
         wl_q <= WL_IDLE;
         cnt_q <= '0;
         dfi_wrlvl_strobe <= 1'b0;
         wl_done_q <= 1'b0;
         wrlvl_delay_q <= DLY_W'(`DTLH_DLY_RESET);
         wrlvl_fail_q <= 1'b0;
      end else begin
         dfi_wrlvl_strobe <= 1'b0;
         wl_done_q <= 1'b0;
         case (wl_q)
            WL_IDLE: begin
               if (grant[`DTLH_CH_WRLVL]) begin
                  wl_q <= WL_GAP;
                  cnt_q <= GAP_CYC;
                  wrlvl_delay_q <= DLY_W'(`DTLH_DLY_RESET);
                  wrlvl_fail_q <= 1'b0;
               end
            end
            WL_GAP: begin
               if (cnt_q <= `DTLH_CNT_W'(1)) begin
                  wl_q <= WL_STROBE;
                  dfi_wrlvl_strobe <= 1'b1;
               end else begin
                  cnt_q <= cnt_q - `DTLH_CNT_W'(1);
               end
            end
            WL_STROBE: begin
               wl_q <= WL_SAMPLE;
               cnt_q <= WAIT_CYC;
            end
            WL_SAMPLE: begin
               if (cnt_q <= `DTLH_CNT_W'(1)) begin
                  if (dfi_wrlvl_resp) begin
                     wl_q <= WL_DONE;
                     wl_done_q <= 1'b1;
                  end else if (wrlvl_delay_q == DLY_MAX) begin
                     // sweep exhausted: release the phy rather than hang in training
                     wl_q <= WL_DONE;
                     wl_done_q <= 1'b1;
                     wrlvl_fail_q <= 1'b1;
                  end else begin
                     wrlvl_delay_q <= wrlvl_delay_q + DLY_W'(1);
                     wl_q <= WL_GAP;
                     cnt_q <= GAP_CYC;
                  end
               end else begin
                  cnt_q <= cnt_q - `DTLH_CNT_W'(1);
               end
            end
            WL_DONE: begin
               // idle before a back-to-back grant can arrive
               wl_q <= WL_IDLE;
            end
            default: begin
               wl_q <= WL_IDLE;
            end
         endcase
      end
   end

   a_wakeup_passes: assert property (@(posedge clock) disable iff (!resetn)
      lp_in.req |=> dfi_wrlp.req && (dfi_wrlp.wakeup == $past(lp_in.wakeup)))
      else $error("wakeup selector not driven with request");
   a_lp_no_wait: assert property (@(posedge clock) disable iff (!resetn)
      !lp_in.req |=> !dfi_wrlp.req)
      else $error("low-power request held waiting on ack");
   a_one_training: assert property (@(posedge clock) disable iff (!resetn)
      $onehot0({dfi_rdlvl_en, dfi_rdlvl_gate_en, dfi_wrlvl_en}))
      else $error("two training enables at once");
   a_delay_steps: assert property (@(posedge clock) disable iff (!resetn)
      (wl_q == WL_SAMPLE) && (cnt_q <= `DTLH_CNT_W'(1)) && !dfi_wrlvl_resp
      && (wrlvl_delay_q != DLY_MAX) |=> wrlvl_delay_q == $past(wrlvl_delay_q) + DLY_W'(1))
      else $error("delay not stepped on low response");
   a_level_found: assert property (@(posedge clock) disable iff (!resetn)
      (wl_q == WL_SAMPLE) && (cnt_q <= `DTLH_CNT_W'(1)) && dfi_wrlvl_resp
      |=> wl_done_q && $stable(wrlvl_delay_q) ##1 !dfi_wrlvl_en)
      else $error("write leveling did not finish on high response");
   a_strobe_in_en: assert property (@(posedge clock) disable iff (!resetn)
      dfi_wrlvl_strobe |-> dfi_wrlvl_en ##1 !dfi_wrlvl_strobe)
      else $error("strobe outside write training");
   a_strobe_spaced: assert property (@(posedge clock) disable iff (!resetn)
      dfi_wrlvl_strobe |=> !dfi_wrlvl_strobe [*8])
      else $error("write strobes too close together");
   a_fail_at_max: assert property (@(posedge clock) disable iff (!resetn)
      $rose(wrlvl_fail_q) |-> wrlvl_delay_q == DLY_MAX)
      else $error("sweep failed before reaching maximum delay");
   a_wr_done_pulse: assert property (@(posedge clock) disable iff (!resetn)
      $fell(dfi_wrlvl_en) |-> train_done_q[`DTLH_CH_WRLVL])
      else $error("write training ended without done pulse");
   a_wr_cs_capture: assert property (@(posedge clock) disable iff (!resetn)
      grant[`DTLH_CH_WRLVL] && dfi_wrlvl_req
      |=> wr_cs_n_q == $past(dfi_wrlvl_cs_n))
      else $error("write training select not captured at grant");
   a_rd_cs_capture: assert property (@(posedge clock) disable iff (!resetn)
      grant[`DTLH_CH_RDLVL] && dfi_rdlvl_req
      |=> ch_cs_q[`DTLH_CH_RDLVL] == $past(dfi_rdlvl_cs_n))
      else $error("read training select not captured at grant");
endmodule
`default_nettype wire

/* dtlh_phy_model.sv */
// behavioural phy facing the training and write-path low-power handshakes
`timescale 1ns/1ps
`default_nettype none
module dtlh_phy_model #(
   parameter int RD_LAT = 5
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [2:0] cmd,
   input wire logic [1:0] cs,
   input wire logic [7:0] wr_need,
   input wire logic ack_on,
   input wire logic [2:0] en,
   input wire logic strobe,
   input wire logic lp_req,
   output logic rd_req,
   output logic gate_req,
   output logic wr_req,
   output logic [1:0] rd_cs_n,
   output logic [1:0] wr_cs_n,
   output logic rd_resp,
   output logic wr_resp,
   output logic lp_ack
);
   logic [2:0] pend_q;
   logic [7:0] cnt_q;
   logic [7:0] nstb_q;
   // a request is held until its enable has been seen
   always_ff @(posedge clock) begin
      if (!resetn)
         pend_q <= 3'h0;
      else
         pend_q <= (pend_q | cmd) & ~en;
   end
   assign rd_req = cmd[0] | pend_q[0];
   assign gate_req = cmd[1] | pend_q[1];
   assign wr_req = cmd[2] | pend_q[2];
   // released selects show the inverse, never a stale value
   assign rd_cs_n = (rd_req | gate_req) ? cs : ~cs;
   assign wr_cs_n = wr_req ? cs : ~cs;
   always_ff @(posedge clock) begin
      if (!resetn || !(en[0] | en[1]))
         cnt_q <= 8'h00;
      else if (cnt_q != 8'hFF)
         cnt_q <= cnt_q + 8'h01;
   end
   assign rd_resp = (en[0] | en[1]) && (cnt_q == RD_LAT);
   always_ff @(posedge clock) begin
      if (!resetn || !en[2])
         nstb_q <= 8'h00;
      else if (strobe)
         nstb_q <= nstb_q + 8'h01;
   end
   // aligned only once more than wr_need strobes have been seen, so the sweep must climb
   assign wr_resp = en[2] && (nstb_q > wr_need);
   // ack is optional; ack_on low models a phy that never answers
   always_ff @(posedge clock) begin
      lp_ack <= resetn & ack_on & lp_req;
   end
endmodule
`default_nettype wire

/* tb_dfi_training_lowpower_handshake.sv */
// self-checking bench for the training and low-power handshake controller
`timescale 1ns/1ps
`default_nettype none
module tb_dfi_training_lowpower_handshake;
   import dtlh_pkg::*;
   logic clock = 1'h0;
   logic resetn = 1'h0;
   dtlh_lp_t lp_in = '0;
   dtlh_lp_t dfi_wrlp;
   logic [2:0] self_start = 3'h0;
   logic [2:0] cmd = 3'h0;
   logic [1:0] cs = 2'h3;
   logic [7:0] wr_need = 8'h00;
   logic ack_on = 1'h0;
   logic ack, seen, rd_req, gate_req, wr_req, rd_resp, wr_resp, strobe, fail;
   logic [2:0] en, done, phy_init;
   logic [1:0] rd_cs_in, wr_cs_in, rd_cs_q, wr_cs_q;
   logic [5:0] dly;
   int mismatches = 0;
   int n_compared = 0;
   always #20 clock = ~clock;
   dtlh_ctrl #(.CS_W(2), .DLY_W(6)) dtlh_ctrl_inst (.clock(clock), .resetn(resetn),
      .lp_in(lp_in), .dfi_wrlp(dfi_wrlp), .dfi_wrlp_ack(ack), .wrlp_ack_seen_q(seen),
      .dfi_rdlvl_req(rd_req), .dfi_rdlvl_cs_n(rd_cs_in), .dfi_rdlvl_gate_req(gate_req),
      .dfi_rdlvl_resp(rd_resp), .dfi_wrlvl_req(wr_req), .dfi_wrlvl_cs_n(wr_cs_in),
      .dfi_wrlvl_resp(wr_resp), .self_start(self_start), .dfi_rdlvl_en(en[0]),
      .dfi_rdlvl_gate_en(en[1]), .dfi_wrlvl_en(en[2]), .dfi_wrlvl_strobe(strobe),
      .train_done_q(done), .train_phy_init_q(phy_init), .rd_cs_n_q(rd_cs_q),
      .wr_cs_n_q(wr_cs_q), .wrlvl_delay_q(dly), .wrlvl_fail_q(fail));
   dtlh_phy_model dtlh_phy_model_inst (.clock(clock), .resetn(resetn), .cmd(cmd), .cs(cs),
      .wr_need(wr_need), .ack_on(ack_on), .en(en), .strobe(strobe), .lp_req(dfi_wrlp.req),
      .rd_req(rd_req), .gate_req(gate_req), .wr_req(wr_req), .rd_cs_n(rd_cs_in),
      .wr_cs_n(wr_cs_in), .rd_resp(rd_resp), .wr_resp(wr_resp), .lp_ack(ack));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      if (mismatches == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // every wakeup code passes through while the phy does not answer, then the ack is seen and cleared
   task automatic t_lowpower;
      for (int w = 0; w < 16; w++) begin
         lp_in = {1'h1, w[3:0]};
         @(negedge clock);
         chk({3'h0, dfi_wrlp}, {4'h1, w[3:0]});
      end
      ack_on = 1'h1;
      repeat (3) @(negedge clock);
      chk({7'h00, seen}, 8'h01);
      lp_in = '0;
      ack_on = 1'h0;
      repeat (3) @(negedge clock);
      chk({7'h00, seen}, 8'h00);
   endtask
   // phy or own-initiative start for one or more channels
   task automatic go(input logic phy, input logic [2:0] m, input logic [1:0] c,
         input logic [7:0] need);
      cs = c;
      wr_need = need;
      if (phy)
         cmd = m;
      else
         self_start = m;
      @(negedge clock);
      cmd = 3'h0;
      self_start = 3'h0;
   endtask
   // follow one session from grant to completion
   task automatic sess(input int ch, input logic phy);
      logic saw;
      int k;
      saw = 1'h0;
      k = 0;
      while (en[ch] !== 1'h1 && k < 4) begin
         @(negedge clock);
         k++;
      end
      chk({5'h00, en}, 8'h01 << ch);
      chk({7'h00, phy_init[ch]}, {7'h00, phy});
      k = 0;
      while (en[ch] === 1'h1 && k < 3000) begin
         chk({5'h00, en}, 8'h01 << ch);
         saw = saw | ((ch == 2) ? (wr_resp | fail) : rd_resp);
         @(negedge clock);
         k++;
      end
      chk({7'h00, saw}, 8'h01);
      chk({5'h00, en}, 8'h00);
      chk({7'h00, done[ch]}, 8'h01);
      if (phy && ch < 2)
         chk({6'h00, rd_cs_q}, {6'h00, cs});
      if (phy && ch == 2)
         chk({6'h00, wr_cs_q}, {6'h00, cs});
      if (ch == 2) begin
         chk({2'h0, dly}, (wr_need > 8'h3F) ? 8'h3F : wr_need);
         chk({7'h00, fail}, {7'h00, wr_need > 8'h3F});
      end
   endtask
   initial begin
      repeat (4) @(negedge clock);
      chk({5'h00, en}, 8'h00);
      chk({4'h0, rd_cs_q, wr_cs_q}, 8'h0F);
      resetn = 1'h1;
      t_lowpower();
      go(1'h1, 3'h3, 2'h2, 8'h00);
      sess(0, 1'h1);
      sess(1, 1'h1);
      go(1'h0, 3'h3, 2'h1, 8'h00);
      sess(0, 1'h0);
      sess(1, 1'h0);
      go(1'h1, 3'h4, 2'h1, 8'h03);
      sess(2, 1'h1);
      go(1'h0, 3'h4, 2'h2, 8'h40);
      sess(2, 1'h0);
      go(1'h1, 3'h4, 2'h2, 8'h01);
      sess(2, 1'h1);
      finish_test();
   end
   // sessions total about a thousand cycles; the 50000-cycle limit leaves wide margin
   initial begin
      #(40 * 50000);
      mismatches++;
      finish_test();
   end
endmodule
`default_nettype wire
